// *** hdl/hpa_pkg.sv ***
// Constants, register map and types for the protected-area max-address command block.
// Functional notes
// - Normal set-max completion returns drive select and address bits 27:24 in drive/head.
// - Normal completion clears busy, fault, data request, error; sets drive ready.
// - Abort set-max if unsupported, above capacity, or protection locked or frozen.
// - Abort set-max when not directly after a native-max read.
// - Flag not-found on the second non-volatile set-max since reset.
// - Error completion: busy clear, ready set, drive select, error flag if any bit.
// - After set-max, reads and writes above the new maximum end not-found.
// - Set-max updates identify words 1, 54, 57, 60 and 61.
// - With 48-bit support, identify words 103:100 mirror words 61:60.
// - A failed set-max changes neither identify words nor current maximum.
// - Cylinder limit: words 3,6,55,56 kept; word 1 is min(cyl+1, 16383).
// - Cylinder limit: words 61:60 are word 1 times word 3 times word 6.
// - Cylinder limit: word 54 from total over heads-sectors, capped; 58:57 is product.
// - Address limit: words 61:60 are new maximum plus one.
// - Without geometry support and large total, geometry words are zeroed.
// - Geometry with address limit: word 1 is total over 3 times 6, capped.
// - Geometry with address limit: word 54 from total, 16383 when large; 58:57 product.
// - Password-set is code F9h, features 01h, one-sector data-out transfer.
// - Abort password-set if unsupported, locked or frozen.
// - Abort may be set when the requested action cannot be carried out.
// - Set-max is F9h with features 00h; new maximum in address registers.
// - Volatility bit one keeps maximum across hard reset; zero reverts.
// - Password is words 1 to 16 of the sector, kept until power cycle.
package hpa_pkg;
  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_FEAT = 8'h00;
  localparam logic [7:0] OFF_SCNT = 8'h04;
  localparam logic [7:0] OFF_LBAL = 8'h08;
  localparam logic [7:0] OFF_LBAM = 8'h0C;
  localparam logic [7:0] OFF_LBAH = 8'h10;
  localparam logic [7:0] OFF_DEVH = 8'h14;
  localparam logic [7:0] OFF_CMD = 8'h18;
  localparam logic [7:0] OFF_ERR = 8'h1C;
  localparam logic [7:0] OFF_CFG = 8'h20;
  localparam logic [7:0] OFF_MAX = 8'h24;
  localparam logic [7:0] OFF_DATA = 8'h28;
  localparam logic [7:0] OFF_IDSEL = 8'h2C;
  localparam logic [7:0] OFF_IDDAT = 8'h30;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ST_BUSY = 7;
  localparam int ST_DRIVE_READY_FLAG = 6;
  localparam int ST_DF = 5;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_NOT_FOUND_BIT = 4;
  localparam int ER_ABORT_BIT = 2;
  localparam int DH_LBA = 6;
  localparam int DH_DEV = 4;
  localparam int CF_SUP = 0;
  localparam int CF_CHS = 1;
  localparam int CF_48 = 2;
  localparam int CF_LOCK = 3;
  localparam int CF_FRZ = 4;
  localparam int CF_HRST = 5;
  localparam int SC_VV = 0;
  // ****************************************************************
  // Codes, limits and reset values
  // ****************************************************************
  localparam logic [7:0] CMD_NATIVE = 8'hF8;
  localparam logic [7:0] CMD_SETMAX = 8'hF9;
  localparam logic [7:0] CMD_READ = 8'h20;
  localparam logic [7:0] CMD_WRITE = 8'h30;
  localparam logic [7:0] FT_ADDR = 8'h00;
  localparam logic [7:0] FT_PWD = 8'h01;
  localparam logic [31:0] CHS_LIMIT = 32'h00FB_FC10;
  localparam logic [15:0] CYL_CAP = 16'h3FFF;
  localparam logic [15:0] WORD_CAP = 16'hFFFF;
  localparam logic [7:0] SECTOR_WORDS = 8'hFF;
  localparam logic [27:0] NATIVE_MAX = 28'h0FF_FFFF;
  localparam logic [7:0] STATUS_RST = 8'h40;
  localparam logic [7:0] CFG_RST = 8'h07;
  localparam logic [15:0] W3_RST = 16'h0010;
  localparam logic [15:0] W6_RST = 16'h003F;
  localparam logic [15:0] W1_RST = 16'h3FFF;
  localparam logic [15:0] W54_RST = 16'h3FFF;
  localparam logic [31:0] W5758_RST = 32'h00FB_FC10;
  localparam logic [31:0] W6061_RST = 32'h0100_0000;

  typedef enum logic [2:0] {
    HPA_IDLE = 3'b001,
    HPA_EXEC = 3'b010,
    HPA_DATA = 3'b100
  } hpa_state_t;
endpackage

// *** hdl/hpa_cmd.sv ***
// APB-reached command interpreter for the protected-area max-address commands.
`timescale 1ns/1ps
`default_nettype none
module hpa_cmd
  import hpa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ****************************************************************
  // Bus slave
  // ****************************************************************
  hpa_state_t state;
  logic [7:0] feat, scnt, lbal, lbam, lbah, devh, cmd, status, err, cfg;
  logic [27:0] max_lba, nv_max;
  logic [15:0] w1, w3, w6, w54, w55, w56;
  logic [31:0] w5758, w6061, w100;
  logic [6:0] id_sel;
  logic [7:0] word_cnt;
  logic native_ok;
  logic [1:0] nv_count;
  logic done;
  logic [15:0] pwd [16];

  // One wait state: every access phase takes two cycles.
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire idle = (state == HPA_IDLE);
  wire tf_wr = wr & idle;
  wire cmd_wr = tf_wr & (paddr == OFF_CMD);
  wire hard_rst = tf_wr & (paddr == OFF_CFG) & pwdata[CF_HRST];
  wire data_wr = wr & (state == HPA_DATA) & (paddr == OFF_DATA);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  logic [31:0] next_rdata;
  logic next_err;
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      OFF_FEAT: next_rdata = {24'h00_0000, feat};
      OFF_SCNT: next_rdata = {24'h00_0000, scnt};
      OFF_LBAL: next_rdata = {24'h00_0000, lbal};
      OFF_LBAM: next_rdata = {24'h00_0000, lbam};
      OFF_LBAH: next_rdata = {24'h00_0000, lbah};
      OFF_DEVH: next_rdata = {24'h00_0000, devh};
      OFF_CMD: next_rdata = {24'h00_0000, status};
      OFF_ERR: next_rdata = {24'h00_0000, err};
      OFF_CFG: next_rdata = {24'h00_0000, cfg};
      OFF_MAX: next_rdata = {4'h0, max_lba};
      OFF_DATA: next_rdata = 32'h0000_0000;
      OFF_IDSEL: next_rdata = {25'h000_0000, id_sel};
      OFF_IDDAT: begin
        case (id_sel)
          7'd1: next_rdata = {16'h0000, w1};
          7'd3: next_rdata = {16'h0000, w3};
          7'd6: next_rdata = {16'h0000, w6};
          7'd54: next_rdata = {16'h0000, w54};
          7'd55: next_rdata = {16'h0000, w55};
          7'd56: next_rdata = {16'h0000, w56};
          7'd57: next_rdata = {16'h0000, w5758[15:0]};
          7'd58: next_rdata = {16'h0000, w5758[31:16]};
          7'd60: next_rdata = {16'h0000, w6061[15:0]};
          7'd61: next_rdata = {16'h0000, w6061[31:16]};
          7'd100: next_rdata = {16'h0000, w100[15:0]};
          7'd101: next_rdata = {16'h0000, w100[31:16]};
          default: next_rdata = 32'h0000_0000;
        endcase
      end
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= (psel & penable & ~pready & ~pwrite) ? next_rdata : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & next_err;
    end
  end

  // ****************************************************************
  // Host-written taskfile and configuration
  // ****************************************************************
  // Taskfile writes are ignored while a command runs, as a busy drive does.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feat <= 8'h00;
      scnt <= 8'h00;
      cfg <= CFG_RST;
      id_sel <= 7'h00;
    end else if (tf_wr) begin
      if (paddr == OFF_FEAT) feat <= pwdata[7:0];
      if (paddr == OFF_SCNT) scnt <= pwdata[7:0];
      if (paddr == OFF_CFG) cfg <= {3'b000, pwdata[4:0]};
      if (paddr == OFF_IDSEL) id_sel <= pwdata[6:0];
    end
  end

  // ****************************************************************
  // Identify-word recomputation
  // ****************************************************************
  function automatic logic [31:0] div32(input logic [31:0] a, input logic [31:0] b);
    div32 = (b == 32'h0000_0000) ? 32'h0000_0000 : a / b;
  endfunction

  function automatic logic [31:0] mul3(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] c);
    logic [47:0] p;
    p = {32'h0000_0000, a} * {32'h0000_0000, b} * {32'h0000_0000, c};
    mul3 = p[31:0];
  endfunction

  wire [27:0] req_lba = {devh[3:0], lbah, lbam, lbal};
  wire [16:0] cyl1 = {1'b0, lbah, lbam} + 17'h0_0001;
  logic [31:0] tot, lim, q;
  logic [15:0] n1, n3, n6, n54, n55, n56;
  logic fits;
  always_comb begin
    n3 = w3;
    n6 = w6;
    n55 = w55;
    n56 = w56;
    q = 32'h0000_0000;
    if (!devh[DH_LBA]) begin
      n1 = (cyl1 > {1'b0, CYL_CAP}) ? CYL_CAP : cyl1[15:0];
      tot = mul3(n1, w3, w6);
      fits = (tot != 32'h0000_0000) && (tot <= {4'h0, NATIVE_MAX} + 32'h0000_0001);
      lim = (tot < CHS_LIMIT) ? tot : CHS_LIMIT;
      q = div32(lim, {16'h0000, w55} * {16'h0000, w56});
      n54 = (q > {16'h0000, WORD_CAP}) ? WORD_CAP : q[15:0];
    end else begin
      tot = {4'h0, req_lba} + 32'h0000_0001;
      fits = (req_lba <= NATIVE_MAX);
      lim = tot;
      if (!cfg[CF_CHS] && tot > CHS_LIMIT) begin
        n1 = 16'h0000;
        n3 = 16'h0000;
        n6 = 16'h0000;
        n54 = 16'h0000;
        n55 = 16'h0000;
        n56 = 16'h0000;
      end else if (tot < CHS_LIMIT) begin
        q = div32(tot, {16'h0000, w3} * {16'h0000, w6});
        n1 = (q > {16'h0000, WORD_CAP}) ? WORD_CAP : q[15:0];
        q = div32(tot, {16'h0000, w55} * {16'h0000, w56});
        n54 = q[15:0];
      end else begin
        n1 = CYL_CAP;
        n54 = CYL_CAP;
      end
    end
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  wire locked = cfg[CF_LOCK] | cfg[CF_FRZ];
  wire is_addr = (cmd == CMD_SETMAX) && (feat == FT_ADDR);
  wire is_pwd = (cmd == CMD_SETMAX) && (feat == FT_PWD);
  wire is_rw = (cmd == CMD_READ) || (cmd == CMD_WRITE);
  // Order of checks matters: an out-of-sequence request never counts as a change.
  wire addr_abort_bit = !cfg[CF_SUP] || !fits || locked || !native_ok;
  wire addr_not_found_bit = scnt[SC_VV] && (nv_count != 2'd0);
  wire addr_ok = is_addr && !addr_abort_bit && !addr_not_found_bit;
  wire pwd_abort_bit = !cfg[CF_SUP] || locked;
  logic [7:0] next_err_bits;
  always_comb begin
    next_err_bits = 8'h00;
    if (cmd == CMD_NATIVE) begin
      next_err_bits = 8'h00;
    end else if (is_addr) begin
      next_err_bits[ER_ABORT_BIT] = addr_abort_bit;
      next_err_bits[ER_NOT_FOUND_BIT] = !addr_abort_bit && addr_not_found_bit;
    end else if (is_pwd) begin
      next_err_bits[ER_ABORT_BIT] = pwd_abort_bit;
    end else if (is_rw) begin
      next_err_bits[ER_NOT_FOUND_BIT] = (req_lba > max_lba);
    end else begin
      next_err_bits[ER_ABORT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HPA_IDLE;
      cmd <= 8'h00;
      status <= STATUS_RST;
      err <= 8'h00;
      word_cnt <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        HPA_IDLE: begin
          if (cmd_wr) begin
            cmd <= pwdata[7:0];
            status <= 8'h01 << ST_BUSY;
            state <= HPA_EXEC;
          end
        end
        HPA_EXEC: begin
          err <= next_err_bits;
          if (is_pwd && !pwd_abort_bit) begin
            status <= (8'h01 << ST_DRQ) | (8'h01 << ST_DRIVE_READY_FLAG);
            word_cnt <= 8'h00;
            state <= HPA_DATA;
          end else begin
            status <= (8'h01 << ST_DRIVE_READY_FLAG) | {7'h00, |next_err_bits};
            done <= 1'b1;
            state <= HPA_IDLE;
          end
        end
        HPA_DATA: begin
          if (data_wr) begin
            word_cnt <= word_cnt + 8'h01;
            if (word_cnt == SECTOR_WORDS) begin
              status <= 8'h01 << ST_DRIVE_READY_FLAG;
              done <= 1'b1;
              state <= HPA_IDLE;
            end
          end
        end
        default: state <= HPA_IDLE;
      endcase
    end
  end

  // Password words are data, not control, so they carry no reset.
  always_ff @(posedge pclk) begin
    if (data_wr && word_cnt >= 8'd1 && word_cnt <= 8'd16) begin
      pwd[4'(word_cnt - 8'd1)] <= pwdata[15:0];
    end
  end

  // ****************************************************************
  // Maximum address, sequence flag and change counter
  // ****************************************************************
  wire exec = (state == HPA_EXEC);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      native_ok <= 1'b0;
      nv_count <= 2'd0;
      max_lba <= NATIVE_MAX;
      nv_max <= NATIVE_MAX;
    end else if (hard_rst) begin
      native_ok <= 1'b0;
      nv_count <= 2'd0;
      max_lba <= nv_max;
    end else if (exec) begin
      native_ok <= (cmd == CMD_NATIVE);
      if (addr_ok) begin
        max_lba <= devh[DH_LBA] ? req_lba : 28'(tot - 32'h0000_0001);
        if (scnt[SC_VV]) begin
          nv_max <= devh[DH_LBA] ? req_lba : 28'(tot - 32'h0000_0001);
          nv_count <= nv_count + 2'd1;
        end
      end
    end
  end

  // Only a successful set-max touches identify data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w1 <= W1_RST;
      w3 <= W3_RST;
      w6 <= W6_RST;
      w54 <= W54_RST;
      w55 <= W3_RST;
      w56 <= W6_RST;
      w5758 <= W5758_RST;
      w6061 <= W6061_RST;
      w100 <= W6061_RST;
    end else if (exec && addr_ok) begin
      w1 <= n1;
      w3 <= n3;
      w6 <= n6;
      w54 <= n54;
      w55 <= n55;
      w56 <= n56;
      w5758 <= mul3(n54, n55, n56);
      w6061 <= tot;
      w100 <= cfg[CF_48] ? tot : 32'h0000_0000;
    end
  end

  // Returned address and drive/head follow the command outcome.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lbal <= 8'h00;
      lbam <= 8'h00;
      lbah <= 8'h00;
      devh <= 8'h00;
    end else if (tf_wr && paddr >= OFF_LBAL && paddr <= OFF_DEVH) begin
      if (paddr == OFF_LBAL) lbal <= pwdata[7:0];
      if (paddr == OFF_LBAM) lbam <= pwdata[7:0];
      if (paddr == OFF_LBAH) lbah <= pwdata[7:0];
      if (paddr == OFF_DEVH) devh <= pwdata[7:0];
    end else if (exec && cmd == CMD_NATIVE) begin
      {devh[3:0], lbah, lbam, lbal} <= NATIVE_MAX;
    end else if (exec && addr_ok && !devh[DH_LBA]) begin
      {devh[3:0], lbah, lbam, lbal} <= 28'(tot - 32'h0000_0001);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_exec_one_cycle: assert property (cmd_wr |=> exec ##1 !status[ST_BUSY])
    else $error("command did not leave busy after one cycle");
  a_normal_status: assert property (done && err == 8'h00 |-> status == STATUS_RST)
    else $error("normal completion status wrong");
  a_err_flag: assert property (done |-> status[ST_ERR] == (err != 8'h00))
    else $error("error flag does not match error byte");
  a_seq_abort: assert property (exec && is_addr && !native_ok |=> err[ER_ABORT_BIT])
    else $error("out-of-sequence set-max not aborted");
  a_second_nv: assert property (exec && is_addr && !addr_abort_bit && scnt[SC_VV]
    && nv_count != 2'd0 |=> err[ER_NOT_FOUND_BIT] && $stable(max_lba))
    else $error("second non-volatile change not flagged");
  a_fail_keeps: assert property (exec && is_addr && !addr_ok
    |=> $stable(max_lba) && $stable(w6061) && $stable(w1))
    else $error("failed set-max changed state");
  // The host may write the next command right away, so flag and error byte are seen together.
  a_above_max: assert property (exec && is_rw && req_lba > max_lba
    |=> err[ER_NOT_FOUND_BIT] && status[ST_ERR])
    else $error("access above maximum not rejected");
  a_lba_words: assert property (exec && addr_ok && devh[DH_LBA]
    |=> w6061 == {4'h0, max_lba} + 32'h0000_0001)
    else $error("words 61:60 not maximum plus one");
  a_mirror_48: assert property (exec && addr_ok && cfg[CF_48] |=> w100 == w6061)
    else $error("48-bit words differ from 61:60");
  a_lock_abort: assert property (exec && (is_pwd || is_addr) && locked
    |=> err[ER_ABORT_BIT] && state == HPA_IDLE)
    else $error("locked state did not abort");
  a_pwd_store: assert property (data_wr && word_cnt == 8'd16
    |=> pwd[15] == $past(pwdata[15:0]))
    else $error("last password word not stored");

  c_set_ok: cover property (exec && addr_ok);
  c_pwd_done: cover property (state == HPA_DATA && word_cnt == SECTOR_WORDS ##[1:8] done);
  c_second_nv: cover property (exec && is_addr && addr_not_found_bit && !addr_abort_bit);
  c_reject: cover property (exec && is_rw && req_lba > max_lba);
endmodule
`default_nettype wire

// *** verif/hpa_host.sv ***
// Host adapter model that issues taskfile commands to the block over APB.
`timescale 1ns/1ps
`default_nettype none
module hpa_host
  import hpa_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // The request stays frozen until pready is sampled high; a hang is left to the bench watchdog.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    xfer(1'b0, a, 32'h0000_0000, r, e);
  endtask
  // Each command waits for busy to clear, so the next one only goes out with the drive ready.
  task automatic run_cmd(input logic [7:0] ft, input logic vv, input logic [27:0] a,
      input logic lm, input logic [7:0] code, output logic [7:0] st, output logic [7:0] er);
    logic [31:0] r;
    wr(OFF_FEAT, {24'h00_0000, ft});
    wr(OFF_SCNT, {24'h00_0000, 7'h00, vv});
    wr(OFF_LBAL, {24'h00_0000, a[7:0]});
    wr(OFF_LBAM, {24'h00_0000, a[15:8]});
    wr(OFF_LBAH, {24'h00_0000, a[23:16]});
    wr(OFF_DEVH, {24'h00_0000, 1'b0, lm, 2'b01, a[27:24]});
    wr(OFF_CMD, {24'h00_0000, code});
    // Polling has no limit of its own; a drive that never gets ready is caught by the watchdog.
    do begin
      rd(OFF_CMD, r);
    end while (r[ST_BUSY] !== 1'b0 || r[ST_DRIVE_READY_FLAG] !== 1'b1);
    st = r[7:0];
    rd(OFF_ERR, r);
    er = r[7:0];
  endtask
endmodule
`default_nettype wire

// *** verif/tb_protected_area_max_address_cmd.sv ***
// Self-checking bench for the protected-area max-address command block.
`timescale 1ns/1ps
`default_nettype none
module tb_protected_area_max_address_cmd
  import hpa_pkg::*;
;
  // Words 55 and 56 are taken to hold the same default geometry as words 3 and 6.
  localparam logic [31:0] HS = 32'(W3_RST) * 32'(W6_RST);
  localparam logic [7:0] BAD [3] = '{8'h06, 8'h0F, 8'h17};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, lm;
  logic [7:0] paddr, st, er;
  logic [31:0] pwdata, prdata, r, t;
  logic [27:0] a, l1;
  logic [27:0] cs [6];
  logic [15:0] w1;
  int num_errors, total_checks;
  hpa_cmd hpa_cmd_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  hpa_host hpa_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic logic [15:0] geo(input logic [31:0] n);
    return (n < CHS_LIMIT) ? 16'(n / HS) : CYL_CAP;
  endfunction
  task automatic cmd(input logic [7:0] ft, input logic vv, input logic [27:0] x,
      input logic m, input logic [7:0] c);
    hpa_host_i.run_cmd(ft, vv, x, m, c, st, er);
  endtask
  task automatic setmax(input logic vv, input logic [27:0] x, input logic m);
    cmd(FT_ADDR, 1'b0, 28'h000_0000, 1'b1, CMD_NATIVE);
    cmd(FT_ADDR, vv, x, m, CMD_SETMAX);
  endtask
  task automatic idw(input int i);
    hpa_host_i.wr(OFF_IDSEL, i);
    hpa_host_i.rd(OFF_IDDAT, r);
  endtask
  task automatic idp(input int i);
    logic [15:0] lo;
    idw(i);
    lo = r[15:0];
    idw(i + 1);
    r = {r[15:0], lo};
  endtask
  task automatic aborted;
    chk(er[ER_ABORT_BIT], 1'b1);
    chk({st[ST_BUSY], st[ST_DRIVE_READY_FLAG], st[ST_ERR]}, 3'b011);
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    test_done();
  end
  initial begin
    presetn = 1'b0;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(29431));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    hpa_host_i.rd(OFF_CMD, r);
    chk(r, {24'h00_0000, STATUS_RST});
    hpa_host_i.xfer(1'b0, 8'hFC, 32'h0000_0000, r, e);
    chk(e, 1'b1);
    cmd(FT_ADDR, 1'b1, 28'h000_1000, 1'b1, CMD_SETMAX);
    aborted();
    hpa_host_i.rd(OFF_MAX, r);
    chk(r[27:0], NATIVE_MAX);
    idp(60);
    chk(r, W6061_RST);
    l1 = 28'($urandom_range(0, 32'h00FF_FFFF));
    setmax(1'b1, l1, 1'b1);
    chk(er, 8'h00);
    // A second non-volatile change is sent on purpose here.
    setmax(1'b1, l1 ^ 28'h000_0001, 1'b1);
    chk({er[ER_NOT_FOUND_BIT], st[ST_ERR]}, 2'b11);
    setmax(1'b0, 28'h000_0100, 1'b1);
    chk(er, 8'h00);
    hpa_host_i.wr(OFF_CFG, {24'h00_0000, CFG_RST | 8'h20});
    hpa_host_i.rd(OFF_MAX, r);
    chk(r[27:0], l1);
    a = 28'($urandom_range(0, 32'h00FF_FFFF));
    setmax(1'b1, a, 1'b1);
    chk(er, 8'h00);
    setmax(1'b0, 28'h100_0000, 1'b1);
    aborted();
    hpa_host_i.rd(OFF_MAX, r);
    chk(r[27:0], a);
    for (int i = 0; i < 3; i++) begin
      hpa_host_i.wr(OFF_CFG, {24'h00_0000, BAD[i]});
      setmax(1'b0, 28'h000_0010, 1'b1);
      aborted();
      cmd(FT_PWD, 1'b0, 28'h000_0000, 1'b1, CMD_SETMAX);
      aborted();
    end
    hpa_host_i.wr(OFF_CFG, {24'h00_0000, CFG_RST});
    cmd(FT_PWD, 1'b0, 28'h000_0000, 1'b1, CMD_SETMAX);
    chk(st[ST_DRQ], 1'b1);
    repeat (int'(SECTOR_WORDS) + 1) hpa_host_i.wr(OFF_DATA, $urandom_range(0, 32'h0000_FFFF));
    hpa_host_i.rd(OFF_CMD, r);
    chk(r, {24'h00_0000, STATUS_RST});
    // Totals just below and at the geometry limit, full capacity, random, capped cylinder.
    cs = '{28'h0FB_FC0E, 28'h0FB_FC0F, NATIVE_MAX, 28'h000_0000, 28'h03F_FF00, 28'h000_0000};
    cs[3] = 28'($urandom_range(0, 32'h00FF_FFFF));
    cs[5] = {4'h0, 16'($urandom_range(0, 16381)), 8'h00};
    for (int k = 0; k < 6; k++) begin
      lm = k < 4;
      a = cs[k];
      w1 = (a[23:8] < CYL_CAP) ? a[23:8] + 16'h0001 : CYL_CAP;
      t = lm ? 32'(a) + 32'h0000_0001 : 32'(w1) * HS;
      w1 = lm ? geo(t) : w1;
      setmax(1'b0, a, lm);
      chk(st, STATUS_RST);
      idw(1);
      chk(r[15:0], w1);
      idw(54);
      chk(r[15:0], geo(t));
      idp(57);
      chk(r, 32'(geo(t)) * HS);
      idp(60);
      chk(r, t);
      idp(100);
      chk(r, t);
      if (lm) begin
        hpa_host_i.rd(OFF_DEVH, r);
        chk(r[4:0], {1'b1, a[27:24]});
        cmd(FT_ADDR, 1'b0, a, 1'b1, CMD_READ);
        chk(er, 8'h00);
        cmd(FT_ADDR, 1'b0, a + 28'h000_0001, 1'b1, CMD_WRITE);
        chk(er[ER_NOT_FOUND_BIT], 1'b1);
      end
    end
    test_done();
  end
endmodule
`default_nettype wire
